// [pkg/tdtr_pkg.sv]
// Constants and types of the trigger and resolution command interpreter
package tdtr_pkg;
  // Register addresses on the command port
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  // Opcode high bytes
  localparam logic [7:0] OP_SET_WIDTH = 8'h10;
  localparam logic [7:0] OP_SET_OFFSET = 8'h11;
  localparam logic [7:0] OP_SET_SEARCH = 8'h12;
  localparam logic [7:0] OP_SET_REJECT = 8'h13;
  localparam logic [7:0] OP_SUB_ON = 8'h14;
  localparam logic [7:0] OP_SUB_OFF = 8'h15;
  localparam logic [7:0] OP_RD_TRIG = 8'h16;
  localparam logic [7:0] OP_SET_EDGE = 8'h22;
  localparam logic [7:0] OP_RD_EDGE = 8'h23;
  localparam logic [7:0] OP_SET_EDGE_RES = 8'h24;
  localparam logic [7:0] OP_SET_PAIR_RES = 8'h25;
  localparam logic [7:0] OP_RD_RES = 8'h26;
  localparam logic [7:0] OP_SET_DEAD = 8'h28;
  localparam logic [7:0] OP_RD_DEAD = 8'h29;
  // Values after reset
  localparam logic [11:0] WIDTH_DEF = 12'h014;
  localparam logic [11:0] OFFSET_DEF = 12'hfd8;
  localparam logic [11:0] SEARCH_DEF = 12'h008;
  localparam logic [11:0] REJECT_DEF = 12'h004;
  localparam logic SUB_DEF = 1'b0;
  localparam logic [1:0] EDGE_DEF = 2'h2;
  localparam logic [1:0] EDGE_RES_DEF = 2'h2;
  localparam logic [2:0] LEAD_RES_DEF = 3'h0;
  localparam logic [3:0] PW_RES_DEF = 4'h0;
  localparam logic [1:0] DEAD_DEF = 2'h0;
  // Codes and counts
  localparam logic [1:0] EDGE_PAIR = 2'h0;
  localparam logic [1:0] EDGE_RES_UNUSED = 2'h3;
  localparam logic [3:0] PW_RES_MAX = 4'hd;
  localparam logic [2:0] TRIG_WORDS = 3'h5;
  localparam logic [2:0] ONE_WORD = 3'h1;
  typedef enum logic [3:0] {
    S_INIT = 4'b0001,
    S_IDLE = 4'b0010,
    S_WAIT_WR = 4'b0100,
    S_WAIT_RD = 4'b1000
  } tdtr_state_t;
  typedef enum logic [2:0] {
    SEL_WIDTH, SEL_OFFSET, SEL_SEARCH, SEL_REJECT,
    SEL_EDGE, SEL_EDGE_RES, SEL_PAIR_RES, SEL_DEAD
  } tdtr_sel_t;
endpackage

// [pkg/tdtr_cfg_if.sv]
// Interface between the command sequencer and the settings bank
`timescale 1ns/1ps
`default_nettype none
interface tdtr_cfg_if;
  import tdtr_pkg::*;
  logic load_def;
  logic wr_en;
  tdtr_sel_t wr_sel;
  logic [15:0] wr_data;
  logic sub_set;
  logic sub_clr;
  logic [11:0] width;
  logic [11:0] offset;
  logic [11:0] search;
  logic [11:0] reject;
  logic sub_en;
  logic [1:0] edge_mode;
  logic [1:0] edge_res;
  logic [2:0] lead_res;
  logic [3:0] pw_res;
  logic [1:0] dead;
  modport ctrl (output load_def, wr_en, wr_sel, wr_data, sub_set, sub_clr,
    input width, offset, search, reject, sub_en, edge_mode, edge_res, lead_res, pw_res, dead);
  modport bank (input load_def, wr_en, wr_sel, wr_data, sub_set, sub_clr,
    output width, offset, search, reject, sub_en, edge_mode, edge_res, lead_res, pw_res, dead);
endinterface
`default_nettype wire

// [core/tdtr_cfg_bank.sv]
// Settings bank holding the trigger window, edge and resolution values
`timescale 1ns/1ps
`default_nettype none
module tdtr_cfg_bank (
  input wire logic clk,
  input wire logic reset_n,
  tdtr_cfg_if.bank cfg
);
  import tdtr_pkg::*;
  logic [11:0] width_q, offset_q, search_q, reject_q;
  logic sub_q;
  logic [1:0] edge_q, edge_res_q, dead_q;
  logic [2:0] lead_q;
  logic [3:0] pw_q;
  logic [15:0] w;
  logic res_ok, pw_ok;

  // Field checks on the parameter word
  assign w = cfg.wr_data;
  assign res_ok = w[1:0] != EDGE_RES_UNUSED;
  assign pw_ok = w[11:8] <= PW_RES_MAX;

  // Settings registers, defaults on reset and on load request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      width_q <= WIDTH_DEF;
      offset_q <= OFFSET_DEF;
      search_q <= SEARCH_DEF;
      reject_q <= REJECT_DEF;
      sub_q <= SUB_DEF;
      edge_q <= EDGE_DEF;
      edge_res_q <= EDGE_RES_DEF;
      lead_q <= LEAD_RES_DEF;
      pw_q <= PW_RES_DEF;
      dead_q <= DEAD_DEF;
    end else if (cfg.load_def) begin
      width_q <= WIDTH_DEF;
      offset_q <= OFFSET_DEF;
      search_q <= SEARCH_DEF;
      reject_q <= REJECT_DEF;
      sub_q <= SUB_DEF;
      edge_q <= EDGE_DEF;
      edge_res_q <= EDGE_RES_DEF;
      lead_q <= LEAD_RES_DEF;
      pw_q <= PW_RES_DEF;
      dead_q <= DEAD_DEF;
    end else begin
      if (cfg.sub_set) sub_q <= 1'b1;
      if (cfg.sub_clr) sub_q <= 1'b0;
      if (cfg.wr_en) begin
        unique case (cfg.wr_sel)
          SEL_WIDTH: width_q <= w[11:0];
          SEL_OFFSET: offset_q <= w[11:0];
          SEL_SEARCH: search_q <= w[11:0];
          SEL_REJECT: reject_q <= w[11:0];
          SEL_EDGE: edge_q <= w[1:0];
          SEL_EDGE_RES: if (res_ok) edge_res_q <= w[1:0];
          SEL_PAIR_RES: if (pw_ok) begin
            lead_q <= w[2:0];
            pw_q <= w[11:8];
          end
          SEL_DEAD: dead_q <= w[1:0];
        endcase
      end
    end
  end

  // Settings out to the sequencer and the pins
  assign cfg.width = width_q;
  assign cfg.offset = offset_q;
  assign cfg.search = search_q;
  assign cfg.reject = reject_q;
  assign cfg.sub_en = sub_q;
  assign cfg.edge_mode = edge_q;
  assign cfg.edge_res = edge_res_q;
  assign cfg.lead_res = lead_q;
  assign cfg.pw_res = pw_q;
  assign cfg.dead = dead_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_width_apply: assert property (cfg.wr_en && cfg.wr_sel == SEL_WIDTH && !cfg.load_def
    |=> width_q == $past(w[11:0])) else $error("window width not applied");
  a_pw_invalid_kept: assert property (cfg.wr_en && cfg.wr_sel == SEL_PAIR_RES && !pw_ok
    |=> $stable(pw_q) && $stable(lead_q)) else $error("invalid width resolution taken");
  a_edge_res_unused: assert property (cfg.wr_en && cfg.wr_sel == SEL_EDGE_RES && !res_ok
    |=> $stable(edge_res_q)) else $error("unused edge resolution code taken");
endmodule
`default_nettype wire

// [core/tdtr_cmd.sv]
// Command interpreter for trigger window, edge, resolution and dead time settings
`timescale 1ns/1ps
`default_nettype none
module tdtr_cmd (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic busy,
  output logic [11:0] window_width,
  output logic [11:0] window_offset,
  output logic [11:0] search_margin,
  output logic [11:0] reject_margin,
  output logic trig_sub_en,
  output logic [1:0] edge_mode,
  output logic [1:0] edge_res,
  output logic [2:0] lead_res,
  output logic [3:0] pw_res,
  output logic [1:0] dead_time
);
  import tdtr_pkg::*;

  tdtr_cfg_if cfg ();

  tdtr_state_t state_q, state_d;
  tdtr_sel_t sel_q, sel_d;
  logic [7:0] op_q, op_d;
  logic [2:0] left_q, left_d;
  logic [2:0] idx_q, idx_d;
  logic [15:0] rdata_q, rdata_d;
  logic bad_q, bad_d;

  logic cmd_wr, cmd_rd, st_rd;
  logic [7:0] op_in;
  logic accept;
  logic dec_wr;
  tdtr_sel_t dec_sel;
  logic [2:0] dec_rd_n;
  logic dec_sub_on, dec_sub_off;
  logic dec_bad;
  logic word_wr, word_rd, last_rd;
  logic [15:0] off_ext;
  logic [15:0] trig_word;
  logic [15:0] res_word;
  logic [15:0] rd_word;
  logic [15:0] status_word;

  // Settings bank
  tdtr_cfg_bank u_bank (
    .clk(clk),
    .reset_n(reset_n),
    .cfg(cfg)
  );

  // Address decode on the command port
  assign cmd_wr = wr && (addr == ADDR_CMD);
  assign cmd_rd = rd && (addr == ADDR_CMD);
  assign st_rd = rd && (addr == ADDR_STATUS);
  assign op_in = wdata[15:8];

  // An opcode is taken only in idle, never while a transfer is pending
  assign accept = (state_q == S_IDLE) && cmd_wr;

  // Opcodes that carry one parameter word
  assign dec_wr = (op_in == OP_SET_WIDTH) || (op_in == OP_SET_OFFSET) ||
                  (op_in == OP_SET_SEARCH) || (op_in == OP_SET_REJECT) ||
                  (op_in == OP_SET_EDGE) || (op_in == OP_SET_EDGE_RES) ||
                  (op_in == OP_SET_PAIR_RES) || (op_in == OP_SET_DEAD);

  // Target setting of a parameter opcode
  assign dec_sel = (op_in == OP_SET_OFFSET) ? SEL_OFFSET :
                   (op_in == OP_SET_SEARCH) ? SEL_SEARCH :
                   (op_in == OP_SET_REJECT) ? SEL_REJECT :
                   (op_in == OP_SET_EDGE) ? SEL_EDGE :
                   (op_in == OP_SET_EDGE_RES) ? SEL_EDGE_RES :
                   (op_in == OP_SET_PAIR_RES) ? SEL_PAIR_RES :
                   (op_in == OP_SET_DEAD) ? SEL_DEAD : SEL_WIDTH;

  // Number of words a read opcode returns
  assign dec_rd_n = (op_in == OP_RD_TRIG) ? TRIG_WORDS :
                    ((op_in == OP_RD_EDGE) || (op_in == OP_RD_RES) ||
                     (op_in == OP_RD_DEAD)) ? ONE_WORD : 3'h0;

  // Opcodes acting at once
  assign dec_sub_on = op_in == OP_SUB_ON;
  assign dec_sub_off = op_in == OP_SUB_OFF;
  assign dec_bad = !dec_wr && (dec_rd_n == 3'h0) && !dec_sub_on && !dec_sub_off;

  // Transfers at the command location during a wait
  assign word_wr = (state_q == S_WAIT_WR) && cmd_wr;
  assign word_rd = (state_q == S_WAIT_RD) && cmd_rd;
  assign last_rd = word_rd && (left_q == ONE_WORD);

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    op_d = op_q;
    left_d = left_q;
    idx_d = idx_q;
    unique case (state_q)
      S_INIT: begin
        state_d = S_IDLE;
      end
      S_IDLE: begin
        if (accept) begin
          op_d = op_in;
          if (dec_wr) begin
            state_d = S_WAIT_WR;
            sel_d = dec_sel;
          end else if (dec_rd_n != 3'h0) begin
            state_d = S_WAIT_RD;
            left_d = dec_rd_n;
            idx_d = 3'h0;
          end
        end
      end
      S_WAIT_WR: begin
        if (word_wr) begin
          state_d = S_IDLE;
        end
      end
      S_WAIT_RD: begin
        if (word_rd) begin
          left_d = left_q - 3'h1;
          idx_d = idx_q + 3'h1;
          if (last_rd) begin
            state_d = S_IDLE;
          end
        end
      end
      default: begin
        state_d = S_INIT;
      end
    endcase
  end

  // Requests to the settings bank
  assign cfg.load_def = state_q == S_INIT;
  assign cfg.wr_en = word_wr;
  assign cfg.wr_sel = sel_q;
  assign cfg.wr_data = wdata;
  assign cfg.sub_set = accept && dec_sub_on;
  assign cfg.sub_clr = accept && dec_sub_off;

  // Trigger configuration words, offset read back sign-extended
  assign off_ext = {{4{cfg.offset[11]}}, cfg.offset};
  assign trig_word = (idx_q == 3'h0) ? {4'h0, cfg.width} :
                     (idx_q == 3'h1) ? off_ext :
                     (idx_q == 3'h2) ? {4'h0, cfg.search} :
                     (idx_q == 3'h3) ? {4'h0, cfg.reject} :
                     {15'h0000, cfg.sub_en};

  // Resolution word depends on the edge detection mode
  assign res_word = (cfg.edge_mode == EDGE_PAIR) ?
                    {4'h0, cfg.pw_res, 5'h00, cfg.lead_res} :
                    {14'h0000, cfg.edge_res};

  // Word returned for the pending read opcode
  assign rd_word = (op_q == OP_RD_TRIG) ? trig_word :
                   (op_q == OP_RD_EDGE) ? {14'h0000, cfg.edge_mode} :
                   (op_q == OP_RD_RES) ? res_word :
                   {14'h0000, cfg.dead};

  // Status word: last opcode, unknown opcode flag, words left, wait flags
  assign status_word = {op_q, 1'b0, bad_q, left_q, state_q == S_WAIT_RD,
                        state_q == S_WAIT_WR, state_q != S_IDLE};

  // Read data for the cycle after a read strobe, zero elsewhere
  assign rdata_d = word_rd ? rd_word :
                   st_rd ? status_word : 16'h0000;

  // Unknown opcode flag, a new hit beats the clear by a status read
  assign bad_d = (accept && dec_bad) ? 1'b1 :
                 st_rd ? 1'b0 : bad_q;

  // Sequencer registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= S_INIT;
      sel_q <= SEL_WIDTH;
      op_q <= 8'h00;
      left_q <= 3'h0;
      idx_q <= 3'h0;
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      op_q <= op_d;
      left_q <= left_d;
      idx_q <= idx_d;
    end
  end

  // Read data and flag registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 16'h0000;
      bad_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      bad_q <= bad_d;
    end
  end

  // Outputs
  assign rdata = rdata_q;
  assign busy = state_q != S_IDLE;
  assign window_width = cfg.width;
  assign window_offset = cfg.offset;
  assign search_margin = cfg.search;
  assign reject_margin = cfg.reject;
  assign trig_sub_en = cfg.sub_en;
  assign edge_mode = cfg.edge_mode;
  assign edge_res = cfg.edge_res;
  assign lead_res = cfg.lead_res;
  assign pw_res = cfg.pw_res;
  assign dead_time = cfg.dead;

  // Checks on the sequencer
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_param_op;
    accept && dec_wr;
  endsequence

  sequence s_param_word;
    (state_q == S_WAIT_WR) && cmd_wr;
  endsequence

  sequence s_trig_op;
    accept && (op_in == OP_RD_TRIG);
  endsequence

  a_wait_holds_op: assert property ((state_q == S_WAIT_WR) && !cmd_wr
    |=> (state_q == S_WAIT_WR) && $stable(sel_q)) else $error("left parameter wait early");

  a_param_word_ends: assert property (s_param_op ##1 s_param_word
    |=> state_q == S_IDLE) else $error("parameter word did not end the wait");

  a_trig_five_words: assert property (s_trig_op
    |=> (state_q == S_WAIT_RD) && (left_q == TRIG_WORDS) && (idx_q == 3'h0))
    else $error("trigger read does not expect five words");

  a_read_hold: assert property ((state_q == S_WAIT_RD) && !cmd_rd
    |=> (state_q == S_WAIT_RD) && (left_q == $past(left_q)))
    else $error("read wait left without a read");

  a_last_read_idle: assert property (last_rd
    |=> (state_q == S_IDLE) && (left_q == 3'h0)) else $error("last word did not end read wait");

  a_trig_first_word: assert property (word_rd && (op_q == OP_RD_TRIG) && (idx_q == 3'h0)
    |=> rdata == {4'h0, $past(cfg.width)}) else $error("first trigger word not window width");

  a_offset_sign: assert property (word_rd && (op_q == OP_RD_TRIG) && (idx_q == 3'h1)
    |=> rdata[15:12] == {4{$past(cfg.offset[11])}}) else $error("offset not sign-extended");

  a_res_pair_word: assert property (word_rd && (op_q == OP_RD_RES)
    && (cfg.edge_mode == EDGE_PAIR)
    |=> (rdata[11:8] == $past(cfg.pw_res)) && (rdata[2:0] == $past(cfg.lead_res)))
    else $error("pair resolution word wrong");

  a_edge_readback: assert property (word_rd && (op_q == OP_RD_EDGE)
    |=> rdata == {14'h0000, $past(cfg.edge_mode)}) else $error("edge code read back wrong");

  a_dead_readback: assert property (word_rd && (op_q == OP_RD_DEAD)
    |=> rdata == {14'h0000, $past(cfg.dead)}) else $error("dead time read back wrong");

  a_sub_enable: assert property (accept && dec_sub_on
    |=> trig_sub_en) else $error("subtraction not enabled");

  a_sub_disable: assert property (accept && dec_sub_off
    |=> !trig_sub_en) else $error("subtraction not disabled");

  a_init_defaults: assert property (state_q == S_INIT
    |=> (state_q == S_IDLE) && (window_width == WIDTH_DEF) && (window_offset == OFFSET_DEF)
    && (search_margin == SEARCH_DEF) && (reject_margin == REJECT_DEF)
    && (dead_time == DEAD_DEF) && (edge_res == EDGE_RES_DEF))
    else $error("defaults not loaded before idle");

  a_edge_set: assert property (word_wr && (sel_q == SEL_EDGE)
    |=> edge_mode == $past(wdata[1:0])) else $error("edge code not applied");

  a_search_low_bits: assert property (word_wr && (sel_q == SEL_SEARCH)
    |=> search_margin == $past(wdata[11:0])) else $error("search margin not low bits");

  a_reject_low_bits: assert property (word_wr && (sel_q == SEL_REJECT)
    |=> reject_margin == $past(wdata[11:0])) else $error("reject margin not low bits");

  a_dead_set: assert property (word_wr && (sel_q == SEL_DEAD)
    |=> dead_time == $past(wdata[1:0])) else $error("dead time not applied");

  a_offset_set: assert property (word_wr && (sel_q == SEL_OFFSET)
    |=> window_offset == $past(wdata[11:0])) else $error("window offset not applied");

  a_edge_res_set: assert property (word_wr && (sel_q == SEL_EDGE_RES)
    && (wdata[1:0] != EDGE_RES_UNUSED)
    |=> edge_res == $past(wdata[1:0])) else $error("edge resolution not applied");

  a_pair_res_set: assert property (word_wr && (sel_q == SEL_PAIR_RES)
    && (wdata[11:8] <= PW_RES_MAX)
    |=> (lead_res == $past(wdata[2:0])) && (pw_res == $past(wdata[11:8])))
    else $error("pair resolution not applied");

  a_width_set: assert property (word_wr && (sel_q == SEL_WIDTH)
    |=> window_width == $past(wdata[11:0])) else $error("window width not applied");
endmodule
`default_nettype wire

// [bench/tdtr_host.sv]
// Bus host model issuing opcodes and parameter words on the command port
`timescale 1ns/1ps
`default_nettype none
module tdtr_host (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd
);
  import tdtr_pkg::*;
  // Quiet bus at time zero
  initial begin
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // One write cycle; wdata is inverted once the strobe drops
  task automatic write_word(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d; // Stale data must not linger
  endtask
  // Opcode and its parameter word on two write cycles with no gap
  task automatic write_pair(input logic [15:0] op_word, input logic [15:0] p);
    @(posedge clk);
    addr <= ADDR_CMD;
    wdata <= op_word;
    wr <= 1'b1;
    @(posedge clk);
    wdata <= p;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~p;
  endtask
  // One read cycle; a single word is fetched per call
  task automatic read_word(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a; // Address moves off once the strobe ends
  endtask
endmodule
`default_nettype wire

// [bench/tdtr_cmd_test.sv]
// Self-checking testbench of the trigger and resolution command interpreter
`timescale 1ns/1ps
`default_nettype none
module tdtr_cmd_test;
  import tdtr_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr;
  logic [15:0] wdata, rdata;
  logic wr, rd, busy, trig_sub_en;
  logic [11:0] window_width, window_offset, search_margin, reject_margin;
  logic [1:0] edge_mode, edge_res, dead_time;
  logic [2:0] lead_res;
  logic [3:0] pw_res;
  int mismatches = 0;
  int n_tests = 0;
  logic [15:0] exp_q[$];
  logic rd_d = 1'b0;
  logic [31:0] seed = 32'h439aab57;

  // Clock at 40 MHz
  always #12.5 clk = ~clk;

  tdtr_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  tdtr_cmd DUT (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .busy(busy), .window_width(window_width), .window_offset(window_offset),
    .search_margin(search_margin), .reject_margin(reject_margin), .trig_sub_en(trig_sub_en),
    .edge_mode(edge_mode), .edge_res(edge_res), .lead_res(lead_res), .pw_res(pw_res),
    .dead_time(dead_time));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Read word seen one cycle after each read strobe, matched to oldest note
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) begin
      check(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);
    end
  end

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    check({15'h0, busy}, 16'h0001);
    reset_n <= 1'b1;
    @(posedge clk);
  endtask

  // Setting opcode, stall check, then the parameter word
  task automatic set_op(input logic [7:0] op, input logic [15:0] p);
    host.write_word(ADDR_CMD, {op, 8'h00});
    #1 check({15'h0, busy}, 16'h0001);
    host.write_word(ADDR_CMD, p);
    #1 check({15'h0, busy}, 16'h0000);
  endtask

  // Read opcode, then one read per noted word
  task automatic get_op(input logic [7:0] op, input logic [15:0] w[$]);
    host.write_word(ADDR_CMD, {op, 8'h00});
    foreach (w[i]) begin
      exp_q.push_back(w[i]);
      host.read_word(ADDR_CMD);
    end
    #1 check({15'h0, busy}, 16'h0000);
  endtask

  task automatic chk_defaults();
    check({4'h0, window_width}, 16'h0014);
    check({4'h0, window_offset}, 16'h0fd8);
    check({4'h0, search_margin}, 16'h0008);
    check({4'h0, reject_margin}, 16'h0004);
    check({14'h0, edge_res}, 16'h0002);
    check({14'h0, dead_time}, 16'h0000);
    check({15'h0, trig_sub_en}, 16'h0000);
    check({15'h0, busy}, 16'h0000);
    get_op(OP_RD_TRIG, '{16'h0014, 16'hffd8, 16'h0008, 16'h0004, 16'h0000});
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out();
  end

  // Main sequence
  initial begin
    logic [11:0] w;
    do_reset();
    #1 chk_defaults();
    // Widths: random in range, then the top value and FFF
    repeat (3) begin
      seed = lfsr(seed);
      w = 12'(seed % 2088) + 12'h001;
      set_op(OP_SET_WIDTH, {seed[15:12], w});
      check({4'h0, window_width}, {4'h0, w});
    end
    set_op(OP_SET_WIDTH, 16'h0828);
    check({4'h0, window_width}, 16'h0828);
    set_op(OP_SET_WIDTH, 16'h0fff);
    // Offset low limit, then 0x028, sign-extended by the host
    set_op(OP_SET_OFFSET, 16'hf800);
    check({4'h0, window_offset}, 16'h0800);
    set_op(OP_SET_OFFSET, 16'h0028);
    // Parameter word right behind its opcode, upper bits ignored
    host.write_pair({OP_SET_REJECT, 8'h00}, 16'hf005);
    #1 check({15'h0, busy}, 16'h0000);
    check({4'h0, reject_margin}, 16'h0005);
    seed = lfsr(seed);
    set_op(OP_SET_SEARCH, {seed[3:0], 12'h032});
    set_op(OP_SET_REJECT, {seed[7:4], 12'h000});
    // Subtraction on, full trigger readback, then off
    host.write_word(ADDR_CMD, {OP_SUB_ON, 8'h00});
    #1 check({15'h0, trig_sub_en}, 16'h0001);
    get_op(OP_RD_TRIG, '{16'h0fff, 16'h0028, 16'h0032, 16'h0000, 16'h0001});
    host.write_word(ADDR_CMD, {OP_SUB_OFF, 8'h00});
    #1 check({15'h0, trig_sub_en}, 16'h0000);
    // Every edge and dead time code, read back
    for (int c = 3; c >= 0; c--) begin
      seed = lfsr(seed);
      set_op(OP_SET_EDGE, {seed[15:2], 2'(c)});
      get_op(OP_RD_EDGE, '{{14'h0, 2'(c)}});
      set_op(OP_SET_DEAD, {seed[31:18], 2'(c)});
      get_op(OP_RD_DEAD, '{{14'h0, 2'(c)}});
    end
    // Pair mode now: pair resolutions, invalid width codes dropped
    set_op(OP_SET_PAIR_RES, 16'h0d07);
    set_op(OP_SET_PAIR_RES, 16'h0e03);
    set_op(OP_SET_PAIR_RES, 16'h0f00);
    check({4'h0, pw_res, 5'h0, lead_res}, 16'h0d07);
    get_op(OP_RD_RES, '{16'h0d07});
    set_op(OP_SET_EDGE, 16'h0002);
    for (int c = 0; c < 4; c++) begin
      set_op(OP_SET_EDGE_RES, {14'h0, 2'(c)});
      get_op(OP_RD_RES, '{{14'h0, (c == 3) ? 2'h2 : 2'(c)}});
    end
    // Read of the command place during a write wait ends nothing
    host.write_word(ADDR_CMD, {OP_SET_REJECT, 8'h00});
    exp_q.push_back(16'h0000);
    host.read_word(ADDR_CMD);
    #1 check({15'h0, busy}, 16'h0001);
    host.write_word(ADDR_CMD, 16'h0001);
    #1 check({4'h0, reject_margin}, 16'h0001);
    // Opcode during a read wait is ignored
    host.write_word(ADDR_CMD, {OP_RD_DEAD, 8'h00});
    host.write_word(ADDR_CMD, {OP_SET_DEAD, 8'h00});
    exp_q.push_back(16'h0000);
    host.read_word(ADDR_CMD);
    #1 check({15'h0, busy}, 16'h0000);
    exp_q.push_back(16'h0000);
    host.read_word(8'h08);
    // Unknown opcode does not stall, flagged in status until read
    host.write_word(ADDR_CMD, 16'h3000);
    #1 check({15'h0, busy}, 16'h0000);
    exp_q.push_back(16'h3040);
    host.read_word(ADDR_STATUS);
    exp_q.push_back(16'h3000);
    host.read_word(ADDR_STATUS);
    // Mid-run reset brings the defaults back
    @(posedge clk);
    do_reset();
    #1 chk_defaults();
    repeat (3) @(posedge clk);
    check(16'(exp_q.size()), 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
